// [logic/dmc_pkg.sv]
// constants and types shared by the display mode control bank
// How it works
// [RULE1] 200-line modes: even lines B8000, odd BA000
// [RULE2] two-colour byte: eight pixels, MSB leftmost
// [RULE3] clear bit black, set bit foreground colour
// [RULE4] four-colour byte: bit pairs, top pair leftmost
// [RULE5] 350-line mode: contiguous 80-byte lines from A0000
// [RULE6] host sets start for second page A8000
// [RULE7] mode held until host rewrites registers
// [RULE8] extended write needs two prior status reads
// [RULE9] read count cleared after write or interruption
// [RULE10] bit 7: negative vsync, blank border
// [RULE11] bit 6: enables legacy compatible modes
// [RULE12] bit 5: palette and overscan writes ignored
// [RULE13] bit 4: sync timing registers locked
// [RULE14] bit 3: four extra character sets
// [RULE15] bit 2: suppress colour text blanking
// [RULE16] bit 1: 132-character row mode
// [RULE17] bit 0: colour simulation modes enabled
// [RULE18] gate register at 3BF, only upper bits unused
// [RULE19] gate bits force mode bits 7 and 1 low
// [RULE20] extra plane register adds plane at BC000
// [RULE21] bit 6 swaps plane 0 and plane 1 bases; code swaps only while bit 4 or 5 is also set
// [RULE22] bits 4/5 select palette, 4 wins
package dmc_pkg;

  localparam logic [9:0]  PORT_MODE_MONO   = 10'h3B8;
  localparam logic [9:0]  PORT_MODE_COLOR  = 10'h3D8;
  localparam logic [9:0]  PORT_EXT_MONO    = 10'h3BB;
  localparam logic [9:0]  PORT_EXT_COLOR   = 10'h3DB;
  localparam logic [9:0]  PORT_GATE        = 10'h3BF;
  localparam logic [9:0]  PORT_PLANE       = 10'h3DD;

  localparam logic [19:0] BASE_EVEN        = 20'hB8000;
  localparam logic [19:0] BASE_ODD         = 20'hBA000;
  localparam logic [19:0] BASE_HIRES       = 20'hA0000;
  localparam logic [19:0] BASE_PLANE_HI    = 20'hBC000;
  localparam logic [19:0] BASE_PAGE1       = 20'hA8000;
  localparam logic [19:0] PAGE0_LAST       = 20'hA6D5F;
  localparam logic [7:0]  LINE_BYTES       = 8'h50;
  localparam logic [8:0]  LINES_200        = 9'h0C8;
  localparam logic [8:0]  LINES_350        = 9'h15E;

  localparam logic [7:0]  EXT_RESET        = 8'h00;
  localparam logic [7:0]  GATE_RESET       = 8'h00;
  localparam logic [7:0]  PLANE_RESET      = 8'h00;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [1:0]  UNLOCK_READS     = 2'h2;

  localparam int EXT_VSYNC_BORDER = 7;
  localparam int EXT_SPECIAL      = 6;
  localparam int EXT_PAL_LOCK     = 5;
  localparam int EXT_CRT_LOCK     = 4;
  localparam int EXT_ALT_CHARSET  = 3;
  localparam int EXT_NO_BLANK     = 2;
  localparam int EXT_WIDE_TEXT    = 1;
  localparam int EXT_COLOR_SIM    = 0;
  localparam int GATE_FULL_EN     = 1;
  localparam int GATE_GRAPH_EN    = 0;
  localparam int MODE_FULL_BIT    = 7;
  localparam int MODE_GRAPH_BIT   = 1;
  localparam int PLANE_SWAP       = 6;
  localparam int PLANE_PAL1       = 5;
  localparam int PLANE_PAL2       = 4;

  typedef enum logic [1:0] {
    DMC_FMT_ONE_BIT = 2'b00,
    DMC_FMT_TWO_BIT = 2'b01,
    DMC_FMT_HIRES   = 2'b10,
    DMC_FMT_TEXT    = 2'b11
  } dmc_format_type;

  typedef enum logic [1:0] {
    DMC_PAL_STANDARD = 2'b00,
    DMC_PAL_EXT1     = 2'b01,
    DMC_PAL_EXT2     = 2'b10
  } dmc_palette_type;

endpackage : dmc_pkg

// [logic/dmc_pixel_unpack.sv]
// unpacks one display byte into pixel indices, registered
`timescale 1ns/1ps
module dmc_pixel_unpack (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 load_i,
  input  wire logic [7:0]           byte_i,
  input  wire dmc_pkg::dmc_format_type format_i,
  input  wire logic [3:0]           fg_color_i,
  input  wire logic [2:0]           pixel_sel_i,
  output logic      [3:0]           pixel_o
);

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] pixel;
  } dmc_unpack_state_type;

  dmc_unpack_state_type state;
  dmc_unpack_state_type next_state;

  always_comb begin
    next_state = state;
    if (load_i) begin
      next_state.data = byte_i;
    end
    unique case (format_i)
      dmc_pkg::DMC_FMT_TWO_BIT: begin
        next_state.pixel = {2'h0, state.data[7 - {pixel_sel_i[1:0], 1'b0} -: 2]}; // [RULE4]
      end
      dmc_pkg::DMC_FMT_ONE_BIT,
      dmc_pkg::DMC_FMT_HIRES: begin
        // msb is the leftmost pixel
        next_state.pixel = state.data[3'h7 - pixel_sel_i] ? fg_color_i : 4'h0; // [RULE2] [RULE3]
      end
      dmc_pkg::DMC_FMT_TEXT: begin
        next_state.pixel = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pixel_o = state.pixel;

endmodule : dmc_pixel_unpack

// [logic/dmc_display_mode_control.sv]
// mode control register bank and display memory address map
`timescale 1ns/1ps
module dmc_display_mode_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic        mode_wr_i,
  input  wire logic        palette_wr_i,
  input  wire logic        overscan_wr_i,
  input  wire logic        crt_timing_wr_i,
  input  wire logic        mono_graphics_en_i,
  input  wire logic        hires_i,
  input  wire logic        two_bit_i,
  input  wire logic        text_i,
  input  wire logic [8:0]  scan_line_i,
  input  wire logic [6:0]  byte_col_i,
  input  wire logic        plane_sel_i,
  input  wire logic        page1_i,
  input  wire logic        fetch_i,
  input  wire logic [7:0]  fetch_data_i,
  input  wire logic [2:0]  pixel_sel_i,
  input  wire logic [3:0]  fg_color_i,
  input  wire logic        color_text_blank_i,
  output logic      [7:0]  ext_mode_o,
  output logic      [7:0]  mode_eff_o,
  output logic      [19:0] fetch_addr_o,
  output logic      [3:0]  pixel_o,
  output logic             vsync_negative_o,
  output logic             border_blank_o,
  output logic             legacy_modes_en_o,
  output logic             palette_wr_en_o,
  output logic             overscan_wr_en_o,
  output logic             crt_timing_wr_en_o,
  output logic             alt_charset_en_o,
  output logic             text_blank_o,
  output logic             wide_text_o,
  output logic             color_sim_o,
  output logic             extra_plane_en_o,
  output logic [1:0]       palette_sel_o,
  output logic             unlocked_o
);

  typedef struct packed {
    logic [7:0]  ext_mode;
    logic [7:0]  gate;
    logic [7:0]  plane;
    logic [7:0]  mode_raw;
    logic [1:0]  reads;
    logic [19:0] addr;
  } dmc_state_type;

  dmc_state_type state;
  dmc_state_type next_state;

  dmc_pkg::dmc_format_type format;

  function automatic logic is_port(input logic [9:0] a, input logic [9:0] m,
                                   input logic [9:0] c);
    is_port = (a == m) || (a == c);
  endfunction : is_port

  function automatic logic [19:0] line_offset(input logic [8:0] line,
                                              input logic [6:0] col);
    line_offset = 20'(line) * 20'(dmc_pkg::LINE_BYTES) + 20'(col);
  endfunction : line_offset

  logic hit_mode;
  logic hit_ext;
  logic ext_accept;
  logic [19:0] base_lo;
  logic [19:0] base_hi;
  logic        plane_active;

  assign hit_mode   = is_port(io_addr_i, dmc_pkg::PORT_MODE_MONO, dmc_pkg::PORT_MODE_COLOR);
  assign hit_ext    = is_port(io_addr_i, dmc_pkg::PORT_EXT_MONO, dmc_pkg::PORT_EXT_COLOR);
  assign ext_accept = io_wr_i && hit_ext && (state.reads == dmc_pkg::UNLOCK_READS); // [RULE8]
  assign plane_active = state.plane[dmc_pkg::PLANE_PAL1] || state.plane[dmc_pkg::PLANE_PAL2];

  always_comb begin
    if (hires_i) begin
      format = dmc_pkg::DMC_FMT_HIRES;
    end else if (text_i) begin
      format = dmc_pkg::DMC_FMT_TEXT;
    end else if (two_bit_i) begin
      format = dmc_pkg::DMC_FMT_TWO_BIT;
    end else begin
      format = dmc_pkg::DMC_FMT_ONE_BIT;
    end
  end

  always_comb begin
    // plane bases swap only while an extended palette is on
    if (plane_active && state.plane[dmc_pkg::PLANE_SWAP]) begin
      base_lo = dmc_pkg::BASE_PLANE_HI; // [RULE21] [RULE22]
      base_hi = dmc_pkg::BASE_EVEN;
    end else begin
      base_lo = dmc_pkg::BASE_EVEN; // [RULE21]
      base_hi = dmc_pkg::BASE_PLANE_HI; // [RULE20]
    end
  end

  always_comb begin
    next_state = state;
    // unlock sequence: reads of the mode port count, any other guarded access resets
    if (io_rd_i && hit_mode) begin
      if (state.reads != dmc_pkg::UNLOCK_READS) begin
        next_state.reads = state.reads + 2'h1; // [RULE8]
      end
    end else if ((io_wr_i || io_rd_i) && (hit_mode || hit_ext)) begin
      next_state.reads = 2'h0; // [RULE9]
    end
    if (ext_accept) begin
      next_state.ext_mode = io_wdata_i; // [RULE7]
    end
    if (io_wr_i && io_addr_i == dmc_pkg::PORT_GATE && mono_graphics_en_i) begin
      next_state.gate = {6'h00, io_wdata_i[1:0]}; // [RULE18]
    end
    if (io_wr_i && io_addr_i == dmc_pkg::PORT_PLANE) begin
      next_state.plane = {1'b0, io_wdata_i[6:0]}; // [RULE20]
    end
    if (mode_wr_i) begin
      next_state.mode_raw = io_wdata_i;
    end
    if (fetch_i) begin
      if (hires_i) begin
        // 350 lines laid end to end, host picks page via start address
        next_state.addr = (page1_i ? dmc_pkg::BASE_PAGE1 : dmc_pkg::BASE_HIRES)
                        + line_offset(scan_line_i, byte_col_i); // [RULE5] [RULE6]
      end else begin
        // odd lines sit one half-plane above the even lines of the same plane
        next_state.addr = (plane_sel_i ? base_hi : base_lo)
                        + (scan_line_i[0] ? dmc_pkg::BASE_ODD - dmc_pkg::BASE_EVEN : 20'h00000)
                        + line_offset({1'b0, scan_line_i[8:1]}, byte_col_i); // [RULE1]
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state.ext_mode <= dmc_pkg::EXT_RESET;
      state.gate     <= dmc_pkg::GATE_RESET;
      state.plane    <= dmc_pkg::PLANE_RESET;
      state.mode_raw <= dmc_pkg::MODE_RESET;
      state.reads    <= 2'h0;
      state.addr     <= 20'h00000;
    end else begin
      state <= next_state;
    end
  end

  dmc_pixel_unpack u_unpack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (fetch_i),
    .byte_i      (fetch_data_i),
    .format_i    (format),
    .fg_color_i  (fg_color_i),
    .pixel_sel_i (pixel_sel_i),
    .pixel_o     (pixel_o)
  );

  always_comb begin
    mode_eff_o = state.mode_raw;
    if (!state.gate[dmc_pkg::GATE_FULL_EN]) begin
      mode_eff_o[dmc_pkg::MODE_FULL_BIT] = 1'b0; // [RULE19]
    end
    if (!state.gate[dmc_pkg::GATE_GRAPH_EN]) begin
      mode_eff_o[dmc_pkg::MODE_GRAPH_BIT] = 1'b0; // [RULE19]
    end
  end

  always_comb begin
    if (state.plane[dmc_pkg::PLANE_PAL2]) begin
      palette_sel_o = dmc_pkg::DMC_PAL_EXT2; // [RULE22]
    end else if (state.plane[dmc_pkg::PLANE_PAL1]) begin
      palette_sel_o = dmc_pkg::DMC_PAL_EXT1;
    end else begin
      palette_sel_o = dmc_pkg::DMC_PAL_STANDARD;
    end
  end

  assign ext_mode_o         = state.ext_mode;
  assign fetch_addr_o       = state.addr;
  assign vsync_negative_o   = state.ext_mode[dmc_pkg::EXT_VSYNC_BORDER]; // [RULE10]
  assign border_blank_o     = state.ext_mode[dmc_pkg::EXT_VSYNC_BORDER]; // [RULE10]
  assign legacy_modes_en_o  = state.ext_mode[dmc_pkg::EXT_SPECIAL]; // [RULE11]
  assign palette_wr_en_o    = palette_wr_i && !state.ext_mode[dmc_pkg::EXT_PAL_LOCK]; // [RULE12]
  assign overscan_wr_en_o   = overscan_wr_i && !state.ext_mode[dmc_pkg::EXT_PAL_LOCK]; // [RULE12]
  assign crt_timing_wr_en_o = crt_timing_wr_i && !state.ext_mode[dmc_pkg::EXT_CRT_LOCK]; // [RULE13]
  assign alt_charset_en_o   = state.ext_mode[dmc_pkg::EXT_ALT_CHARSET]; // [RULE14]
  assign text_blank_o       = color_text_blank_i && !state.ext_mode[dmc_pkg::EXT_NO_BLANK]; // [RULE15]
  assign wide_text_o        = state.ext_mode[dmc_pkg::EXT_WIDE_TEXT]; // [RULE16]
  assign color_sim_o        = state.ext_mode[dmc_pkg::EXT_COLOR_SIM]; // [RULE17]
  assign extra_plane_en_o   = plane_active && state.ext_mode[dmc_pkg::EXT_SPECIAL]; // [RULE11]
  assign unlocked_o         = (state.reads == dmc_pkg::UNLOCK_READS);

endmodule : dmc_display_mode_control

// [test/dmc_display_mode_control_monitor.sv]
// concurrent checks on the mode control bank ports
`timescale 1ns/1ps
module dmc_display_mode_control_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  io_addr_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic        io_wr_i,
  input wire logic        palette_wr_i,
  input wire logic        crt_timing_wr_i,
  input wire logic        color_text_blank_i,
  input wire logic        fetch_i,
  input wire logic        hires_i,
  input wire logic        text_i,
  input wire logic        page1_i,
  input wire logic [8:0]  scan_line_i,
  input wire logic [6:0]  byte_col_i,
  input wire logic [7:0]  ext_mode_o,
  input wire logic [19:0] fetch_addr_o,
  input wire logic        unlocked_o,
  input wire logic        vsync_negative_o,
  input wire logic        border_blank_o,
  input wire logic        palette_wr_en_o,
  input wire logic        crt_timing_wr_en_o,
  input wire logic        text_blank_o
);
  wire wr_ext = io_wr_i && (io_addr_i == 10'h3DB || io_addr_i == 10'h3BB);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_accept; wr_ext && unlocked_o |=> ext_mode_o == $past(io_wdata_i); endproperty
  a_accept: assert property (p_accept) else $error("unlocked write lost");
  property p_refuse; wr_ext && !unlocked_o |=> $stable(ext_mode_o); endproperty
  a_refuse: assert property (p_refuse) else $error("locked write taken");
  property p_relock; wr_ext |=> !unlocked_o; endproperty
  a_relock: assert property (p_relock) else $error("unlock kept");
  property p_hold; !wr_ext |=> $stable(ext_mode_o); endproperty
  a_hold: assert property (p_hold) else $error("mode changed alone");
  property p_vsync; vsync_negative_o == ext_mode_o[7] && border_blank_o == ext_mode_o[7];
  endproperty
  a_vsync: assert property (p_vsync) else $error("sync or border wrong");
  property p_pal; palette_wr_en_o == (palette_wr_i && !ext_mode_o[5]); endproperty
  a_pal: assert property (p_pal) else $error("palette gate wrong");
  property p_crt; crt_timing_wr_en_o == (crt_timing_wr_i && !ext_mode_o[4]); endproperty
  a_crt: assert property (p_crt) else $error("timing gate wrong");
  property p_blank; text_blank_o == (color_text_blank_i && !ext_mode_o[2]); endproperty
  a_blank: assert property (p_blank) else $error("blanking wrong");
  property p_hires;
    fetch_i && hires_i && !text_i |=> fetch_addr_o == ($past(page1_i) ? 20'hA8000 : 20'hA0000)
      + 20'($past(scan_line_i)) * 20'h50 + 20'($past(byte_col_i));
  endproperty
  a_hires: assert property (p_hires) else $error("hires address wrong");
endmodule : dmc_display_mode_control_monitor
bind dmc_display_mode_control dmc_display_mode_control_monitor u_dmc_monitor (.*);

// [test/dmc_host_model.sv]
// host processor issuing single-cycle port reads and writes
`timescale 1ns/1ps
module dmc_host_model (
  input  wire logic clk_i,
  output logic [9:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic       io_wr_o,
  output logic       io_rd_o
);
  initial begin
    io_addr_o = 10'h000;
    io_wdata_o = 8'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
  end
  // two reads then a write is the host's unlock duty
  task automatic access(bit w, logic [9:0] a, logic [7:0] d);
    @(negedge clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = w;
    io_rd_o = !w;
    @(negedge clk_i);
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask : access
endmodule : dmc_host_model

// [test/tb_dmc_display_mode_control.sv]
// self-checking bench for the display mode control bank
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end
module tb_dmc_display_mode_control;
  int bad_count = 0;
  int comparisons = 0;
  int ext = 0;
  int gate = 0;
  logic clk_i = 0, rst_i = 1, text_i = 0, fetch_i = 0, hires_i = 0, two_bit_i = 0;
  logic page1_i = 0, plane_sel_i = 0, mono_graphics_en_i = 0, mode_wr_i, io_wr_i, io_rd_i;
  logic palette_wr_i = 0, overscan_wr_i = 0, crt_timing_wr_i = 0, color_text_blank_i = 0;
  logic vsync_negative_o, border_blank_o, legacy_modes_en_o, palette_wr_en_o, unlocked_o;
  logic overscan_wr_en_o, crt_timing_wr_en_o, alt_charset_en_o, text_blank_o, wide_text_o;
  logic color_sim_o, extra_plane_en_o;
  logic [9:0] io_addr_i;
  logic [7:0] io_wdata_i, ext_mode_o, mode_eff_o, fetch_data_i = 0;
  logic [8:0] scan_line_i = 0;
  logic [6:0] byte_col_i = 0;
  logic [2:0] pixel_sel_i = 0;
  logic [3:0] fg_color_i = 0, pixel_o;
  logic [19:0] fetch_addr_o;
  logic [1:0] palette_sel_o;
  always #50 clk_i = ~clk_i;
  assign mode_wr_i = io_wr_i && io_addr_i == 10'h3B8;
  dmc_host_model u_dmc_host_model (.clk_i(clk_i), .io_addr_o(io_addr_i),
    .io_wdata_o(io_wdata_i), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i));
  dmc_display_mode_control u_dmc_display_mode_control (.*);
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic io(bit w, logic [9:0] a, logic [7:0] d);
    u_dmc_host_model.access(w, a, d);
  endtask : io
  task automatic check_ext;
    logic [3:0] r;
    r = 4'($urandom);
    {palette_wr_i, overscan_wr_i, crt_timing_wr_i, color_text_blank_i} = r;
    #1;
    `CHK(ext_mode_o, 8'(ext))
    `CHK({vsync_negative_o, border_blank_o}, {2{ext[7]}})
    `CHK(legacy_modes_en_o, ext[6])
    `CHK({palette_wr_en_o, overscan_wr_en_o}, r[3:2] & {2{!ext[5]}})
    `CHK(crt_timing_wr_en_o, r[1] & !ext[4])
    `CHK(alt_charset_en_o, ext[3])
    `CHK(text_blank_o, r[0] & !ext[2])
    `CHK({wide_text_o, color_sim_o}, 2'(ext))
  endtask : check_ext
  task automatic unlock(bit mono, logic [7:0] d, int reads);
    for (int i = 0; i < reads; i++) io(0, i[0] ? 10'h3B8 : 10'h3D8, 8'h00);
    io(1, mono ? 10'h3BB : 10'h3DB, d);
    if (reads >= 2) ext = d;
    check_ext;
  endtask : unlock
  task automatic fetch(int ln, int col, logic [19:0] ea);
    logic [3:0] ep;
    scan_line_i = 9'(ln);
    byte_col_i = 7'(col);
    pixel_sel_i = 3'($urandom) & (two_bit_i ? 3'h3 : 3'h7);
    fetch_data_i = 8'($urandom);
    fg_color_i = 4'($urandom);
    fetch_i = 1;
    if (two_bit_i) ep = 4'((fetch_data_i >> (6 - 2 * pixel_sel_i)) & 8'h03);
    else ep = fetch_data_i[7 - pixel_sel_i] ? fg_color_i : 4'h0;
    @(negedge clk_i);
    fetch_i = 0;
    `CHK(fetch_addr_o, ea)
    @(negedge clk_i);
    `CHK(pixel_o, ep)
  endtask : fetch
  initial begin
    int ln;
    int col;
    logic [7:0] d;
    void'($urandom(22));
    repeat (6) @(negedge clk_i);
    rst_i = 0;
    check_ext;
    `CHK({unlocked_o, fetch_addr_o, pixel_o}, 25'h0)
    unlock(0, 8'hA5, 1);
    io(0, 10'h3D8, 8'h00);
    io(1, 10'h3D8, 8'h00);
    io(0, 10'h3D8, 8'h00);
    `CHK(unlocked_o, 1'b0)
    unlock(0, 8'h5A, 0);
    for (int i = 0; i < 8; i++) unlock(i[0], 8'($urandom) | (8'h01 << i), 2 + i % 2);
    unlock(0, 8'h77, 0);
    unlock(1, 8'h40, 2);
    for (int g = 0; g < 5; g++) begin
      d = (g != 0) ? (8'($urandom) & 8'hFC) | 8'(g - 1) : 8'hFF;
      mono_graphics_en_i = (g != 0);
      io(1, 10'h3BF, d);
      if (g != 0) gate = d;
      io(1, 10'h3B8, 8'hFF);
      `CHK(mode_eff_o, 8'h7D | {gate[1], 5'h00, gate[0], 1'b0})
    end
    for (int p = 0; p < 8; p++) begin
      io(1, 10'h3DD, 8'(p << 4));
      `CHK(palette_sel_o, p[0] ? 2'h2 : {1'b0, p[1]})
      `CHK(extra_plane_en_o, p[1:0] != 0)
      repeat (4) begin
        ln = $urandom_range(199);
        two_bit_i = 1'($urandom);
        plane_sel_i = (p[1:0] != 0) & 1'($urandom);
        col = $urandom_range(79);
        fetch(ln, col, ((plane_sel_i ^ (p[2] && p[1:0] != 0)) ? 20'hBC000 : 20'hB8000)
          + 20'((ln % 2) * 'h2000 + ln / 2 * 80 + col));
      end
    end
    hires_i = 1;
    two_bit_i = 0;
    repeat (6) begin
      page1_i = 1'($urandom);
      ln = $urandom_range(349);
      col = $urandom_range(79);
      fetch(ln, col, (page1_i ? 20'hA8000 : 20'hA0000) + 20'(ln * 80 + col));
    end
    check_ext;
    end_of_test;
  end
  initial begin
    #1000000;
    bad_count++;
    end_of_test;
  end
endmodule : tb_dmc_display_mode_control
